// ===== hdl/ppac_regs_map.vh
`ifndef PPAC_REGS_MAP_VH
`define PPAC_REGS_MAP_VH
// ==========================================================
// register offsets within management device 1
`define PPAC_ADDR_STATUS_SECOND   16'h0008
`define PPAC_ADDR_TX_OFF_CTRL     16'h0009
`define PPAC_ADDR_EXT_ABILITY     16'h000B
`define PPAC_ADDR_PAIR_ABILITY    16'h0012
`define PPAC_ADDR_PAIR_CONTROL    16'h0834
// ==========================================================
// fixed read values and reset values
`define PPAC_RST_STATUS_SECOND    16'h8301
`define PPAC_RST_TX_OFF_CTRL      16'h0000
`define PPAC_RST_EXT_ABILITY      16'h0800
`define PPAC_RST_PAIR_ABILITY     16'h0004
`define PPAC_RST_PAIR_CONTROL     16'h8002
// ==========================================================
// field positions
`define PPAC_BIT_TX_OFF           0
`define PPAC_BIT_LEADER           14
`define PPAC_BIT_CTRL_RSVD_TOP    15
`define PPAC_TYPE_MSB             3
`define PPAC_TYPE_LSB             0
// ==========================================================
// type-select codes
`define PPAC_TYPE_FAST            4'h0
`define PPAC_TYPE_GIGABIT         4'h1
`define PPAC_TYPE_LONG_REACH      4'h2
`define PPAC_TYPE_SHORT_REACH     4'h3
`endif

// ===== hdl/ppac_regs.v
// Overview of operation
// - the second status register reads binary 10 in bits 15:14 to show the sublayer is present.
// - bit 9 of the second status register reads 1 to show extended abilities are listed.
// - bit 8 of the second status register reads 1 to show transmit can be switched off.
// - bit 0 of the second status register reads 1 to show local loopback is available.
// - bit 0 at 0x0009 turns transmit output off when 1 and on when 0, resetting to 0.
// - bit 11 of the extended ability register reads 1 to point at the single-pair ability register.
// - the single-pair ability register at 0x0012 ignores all writes.
// - bit 2 of the single-pair ability register reads 1 for long-reach 10 Mb/s support.
// - bits 3, 1 and 0 of the single-pair ability register always read 0.
// - with negotiation off, control bit 14 selects leader when 1 and follower when 0, reset by strap.
// - with negotiation on, the role comes from the negotiation result instead of bit 14.
// - a four-bit writable type-select field resets to 0x2 and encodes the pair phy type.
// - the type-select field applies only with negotiation off and forced configuration on.
`timescale 1ns/1ps
`include "ppac_regs_map.vh"

module ppac_regs (
  input  wire        sys_clk,
  input  wire        rst,
  // management register port
  input  wire [15:0] mgmt_addr,
  input  wire        mgmt_wr,
  input  wire        mgmt_rd,
  input  wire [15:0] mgmt_wdata,
  output reg  [15:0] mgmt_rdata,
  output reg         mgmt_rvalid,
  // strap and negotiation inputs (pins, synchronised)
  input  wire        leader_strap,
  input  wire        autoneg_enable,
  input  wire        forced_config,
  input  wire        an_leader_result,
  input  wire [3:0]  an_type_result,
  // controls to the rest of the sublayer
  output reg         transmit_output_off,
  output reg         leader_role_active,
  output reg  [3:0]  active_pair_type
);

  // ==========================================================
  // local constants
  localparam PIN_COUNT   = 8; // strap, two mode pins, role and four type bits
  localparam PIN_STRAP   = 0;
  localparam PIN_AN_EN   = 1;
  localparam PIN_FORCED  = 2;
  localparam PIN_AN_LEAD = 3;
  localparam PIN_TYPE_LO = 4;
  localparam TYPE_W      = 4;

  // ==========================================================
  // pin synchronisers
  wire [PIN_COUNT-1:0] pin_raw;
  reg  [PIN_COUNT-1:0] pin_meta;
  reg  [PIN_COUNT-1:0] pin_sync;

  // gather every asynchronous level into one bundle
  assign pin_raw = {an_type_result, an_leader_result, forced_config,
                    autoneg_enable, leader_strap};

  // two flops per pin, kept out of reset so that the strap has
  // already settled when reset is released
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
      always @(posedge sys_clk) begin
        pin_meta[gi] <= pin_raw[gi];
        pin_sync[gi] <= pin_meta[gi];
      end
    end
  endgenerate

  // ==========================================================
  // synchronised pin views
  wire              strap_level;
  wire              an_enabled;
  wire              forced_mode;
  wire              an_leader;
  wire [TYPE_W-1:0] an_type;

  // only the second flop of each pair is read from here on
  assign strap_level = pin_sync[PIN_STRAP];
  assign an_enabled  = pin_sync[PIN_AN_EN];
  assign forced_mode = pin_sync[PIN_FORCED];
  assign an_leader   = pin_sync[PIN_AN_LEAD];
  assign an_type     = pin_sync[PIN_COUNT-1:PIN_TYPE_LO];

  // ==========================================================
  // write decode
  wire wr_tx_off_hit;
  wire wr_pair_ctrl_hit;

  // only two addresses hold writable bits; every other write falls away
  assign wr_tx_off_hit    = mgmt_wr && (mgmt_addr == `PPAC_ADDR_TX_OFF_CTRL);
  assign wr_pair_ctrl_hit = mgmt_wr && (mgmt_addr == `PPAC_ADDR_PAIR_CONTROL);

  // ==========================================================
  // writable control state
  reg              tx_off;
  reg              leader_role_select;
  reg [TYPE_W-1:0] pair_phy_type_select;
  reg              strap_pending;

  // transmit-off bit; bits 15:1 of that word have no storage
  always @(posedge sys_clk) begin
    if (rst) begin
      tx_off <= 1'b0;
    end else if (wr_tx_off_hit) begin
      tx_off <= mgmt_wdata[`PPAC_BIT_TX_OFF];
    end
  end

  // one-cycle flag that opens the strap capture after reset
  always @(posedge sys_clk) begin
    if (rst) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  // role bit: loads the strap once after reset, then follows writes;
  // a write in that same cycle wins over the strap
  always @(posedge sys_clk) begin
    if (rst) begin
      leader_role_select <= 1'b0;
    end else if (wr_pair_ctrl_hit) begin
      leader_role_select <= mgmt_wdata[`PPAC_BIT_LEADER];
    end else if (strap_pending) begin
      leader_role_select <= strap_level;
    end
  end

  // type field keeps any written code; only long reach is meaningful
  always @(posedge sys_clk) begin
    if (rst) begin
      pair_phy_type_select <= `PPAC_TYPE_LONG_REACH;
    end else if (wr_pair_ctrl_hit) begin
      pair_phy_type_select <= mgmt_wdata[`PPAC_TYPE_MSB:`PPAC_TYPE_LSB];
    end
  end

  // ==========================================================
  // read data assembly
  wire [15:0] tx_off_word;
  wire [15:0] pair_ctrl_word;
  reg  [15:0] next_rdata;

  // writable words with their reserved bits filled in
  assign tx_off_word    = {15'h0000, tx_off};
  assign pair_ctrl_word = {1'b1, leader_role_select, 10'h000, pair_phy_type_select};

  // fixed words come straight from the constant table
  always @* begin
    case (mgmt_addr)
      `PPAC_ADDR_STATUS_SECOND: begin
        next_rdata = `PPAC_RST_STATUS_SECOND;
      end
      `PPAC_ADDR_TX_OFF_CTRL: begin
        next_rdata = tx_off_word;
      end
      `PPAC_ADDR_EXT_ABILITY: begin
        next_rdata = `PPAC_RST_EXT_ABILITY;
      end
      `PPAC_ADDR_PAIR_ABILITY: begin
        next_rdata = `PPAC_RST_PAIR_ABILITY;
      end
      `PPAC_ADDR_PAIR_CONTROL: begin
        next_rdata = pair_ctrl_word;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // read answer one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // effective controls

  // transmit path follows the stored bit one cycle later
  always @(posedge sys_clk) begin
    if (rst) begin
      transmit_output_off <= 1'b0;
    end else begin
      transmit_output_off <= tx_off;
    end
  end

  // negotiation result overrides the stored role while negotiation runs
  always @(posedge sys_clk) begin
    if (rst) begin
      leader_role_active <= 1'b0;
    end else begin
      if (an_enabled) begin
        leader_role_active <= an_leader;
      end else begin
        leader_role_active <= leader_role_select;
      end
    end
  end

  // stored type applies only with negotiation off and forced mode on
  always @(posedge sys_clk) begin
    if (rst) begin
      active_pair_type <= `PPAC_TYPE_LONG_REACH;
    end else begin
      if (!an_enabled && forced_mode) begin
        active_pair_type <= pair_phy_type_select;
      end else begin
        active_pair_type <= an_type;
      end
    end
  end

endmodule

// ===== verif/ppac_checker.sv
`timescale 1ns/1ps
module ppac_checker (
  input wire        sys_clk,
  input wire        rst,
  input wire [15:0] mgmt_addr,
  input wire        mgmt_wr,
  input wire        mgmt_rd,
  input wire [15:0] mgmt_wdata,
  input wire [15:0] mgmt_rdata,
  input wire        mgmt_rvalid,
  input wire        autoneg_enable,
  input wire        an_leader_result,
  input wire [3:0]  an_type_result,
  input wire        transmit_output_off,
  input wire        leader_role_active,
  input wire [3:0]  active_pair_type
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // read of one address
  sequence rd_at(logic [15:0] a);
    mgmt_rd && mgmt_addr == a;
  endsequence
  a_status_word: assert property (rd_at(16'h0008) |=> mgmt_rdata == 16'h8301)
    else $error("status word wrong");
  a_ext_word: assert property (rd_at(16'h000b) |=> mgmt_rdata == 16'h0800)
    else $error("ext ability word wrong");
  a_ability_word: assert property (rd_at(16'h0012) |=> mgmt_rdata == 16'h0004)
    else $error("pair ability word wrong");
  a_ctrl_shape: assert property (rd_at(16'h0834) |=> (mgmt_rdata & 16'hbff0) == 16'h8000)
    else $error("control reserved bits wrong");
  a_txoff_word: assert property (rd_at(16'h0009) |=>
    mgmt_rdata == {15'h0000, transmit_output_off})
    else $error("tx off readback wrong");
  a_read_answer: assert property (mgmt_rvalid == $past(mgmt_rd))
    else $error("read answer strobe wrong");
  a_txoff_follow: assert property (mgmt_wr && mgmt_addr == 16'h0009 |=> ##1
    transmit_output_off == $past(mgmt_wdata[0], 2))
    else $error("tx off not applied");
  a_role_negotiated: assert property ((autoneg_enable && $stable(an_leader_result))[*4]
    |-> leader_role_active == an_leader_result)
    else $error("negotiated role ignored");
  a_type_negotiated: assert property ((autoneg_enable && $stable(an_type_result))[*4]
    |-> active_pair_type == an_type_result)
    else $error("negotiated type ignored");
  // main scenarios
  cover property (mgmt_wr && mgmt_addr == 16'h0012);
  cover property ($rose(transmit_output_off));
  cover property ($fell(autoneg_enable));
endmodule
bind ppac_regs ppac_checker u_chk (.sys_clk, .rst, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
  .mgmt_rdata, .mgmt_rvalid, .autoneg_enable, .an_leader_result, .an_type_result,
  .transmit_output_off,
  .leader_role_active, .active_pair_type);

// ===== verif/pma_pmd_ability_control_regs_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module pma_pmd_ability_control_regs_test;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] mgmt_addr = '0, mgmt_wdata = '0, d;
  logic        mgmt_wr = 1'b0, mgmt_rd = 1'b0, leader_strap = 1'b0;
  logic        autoneg_enable = 1'b0, forced_config = 1'b0, an_leader_result = 1'b0;
  logic [3:0]  an_type_result = '0;
  wire  [15:0] mgmt_rdata;
  wire         mgmt_rvalid, transmit_output_off, leader_role_active;
  wire  [3:0]  active_pair_type;
  int          errors = 0, total_checks = 0;
  logic [31:0] rows [6] = '{32'h0008_8301, 32'h000b_0800, 32'h0012_0004,
                            32'h0009_0000, 32'h0834_8002, 32'h0010_0000};
  // clock and design
  always #50 sys_clk = ~sys_clk;
  ppac_regs uut (.sys_clk, .rst, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata,
    .mgmt_rvalid, .leader_strap, .autoneg_enable, .forced_config, .an_leader_result,
    .an_type_result, .transmit_output_off, .leader_role_active, .active_pair_type);
  task complete_run;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one strobe cycle, read data captured into d
  task bus(input logic w, input logic [15:0] a, input logic [15:0] wd);
    @(posedge sys_clk);
    mgmt_wr <= w;
    mgmt_rd <= !w;
    mgmt_addr <= a;
    mgmt_wdata <= wd;
    @(posedge sys_clk);
    mgmt_wr <= 1'b0;
    mgmt_rd <= 1'b0;
    @(negedge sys_clk);
    d = mgmt_rdata;
    `CHK("rvalid", !w, mgmt_rvalid)
  endtask
  // wait for synchronised pins to reach outputs
  task settle;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK("type rst", 4'h2, active_pair_type)
    `CHK("txoff rst", 1'b0, transmit_output_off)
    repeat (2) @(posedge sys_clk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i][31:16], 16'h0000);
      `CHK("row", rows[i][15:0], d)
    end
    bus(1'b1, 16'h0012, 16'hffff);
    bus(1'b1, 16'h0009, 16'hffff);
    bus(1'b0, 16'h0012, 16'h0000);
    `CHK("ability", 16'h0004, d)
    bus(1'b0, 16'h0009, 16'h0000);
    `CHK("txctl", 16'h0001, d)
    `CHK("txoff", 1'b1, transmit_output_off)
    bus(1'b1, 16'h0834, 16'h7ff2);
    bus(1'b1, 16'h0009, 16'h0000);
    bus(1'b0, 16'h0834, 16'h0000);
    `CHK("ctrl", 16'hc002, d)
    @(posedge sys_clk);
    forced_config <= 1'b1;
    settle;
    `CHK("txoff", 1'b0, transmit_output_off)
    `CHK("role", 1'b1, leader_role_active)
    `CHK("type", 4'h2, active_pair_type)
    @(posedge sys_clk);
    autoneg_enable <= 1'b1;
    an_leader_result <= 1'b1;
    an_type_result <= 4'h3;
    bus(1'b1, 16'h0834, 16'h0002);
    settle;
    `CHK("role", 1'b1, leader_role_active)
    `CHK("type", 4'h3, active_pair_type)
    @(posedge sys_clk);
    autoneg_enable <= 1'b0;
    forced_config <= 1'b0;
    settle;
    `CHK("type", 4'h3, active_pair_type)
    `CHK("role", 1'b0, leader_role_active)
    bus(1'b1, 16'h0009, 16'h0001);
    bus(1'b0, 16'h0009, 16'h0000);
    `CHK("txctl set", 16'h0001, d)
    @(posedge sys_clk);
    rst <= 1'b1;
    leader_strap <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK("txoff rst", 1'b0, transmit_output_off)
    settle;
    bus(1'b0, 16'h0834, 16'h0000);
    `CHK("strap", 16'hc002, d)
    `CHK("role strap", 1'b1, leader_role_active)
    bus(1'b0, 16'h0009, 16'h0000);
    `CHK("txctl rst", 16'h0000, d)
    complete_run;
  end
  // watchdog
  initial begin
    #100000;
    errors++;
    complete_run;
  end
endmodule
